// ### iu_service_mapper.sv
/*
 * Target-side mapper between received/transmitted SSP IUs and device
 * server service events: command receipt, completion, data-in and
 * data-out with per-tag DATA IU counters.
 * Assumes frame decode upstream presents one parsed IU per rx_valid
 * pulse, and the transmit side takes one IU per tx_valid cycle.
 */
// How it works
// [RULE1] a received COMMAND IU on an open connection pulses cmd_received
// [RULE2] every event carries nexus: connection pair, header LUN and header tag; data-in delivered updates only the pair and tag, ev_lun keeps its last value
// and when an ACK whose tag matches a slot in use meets a received IU in one cycle, ev_tag takes ack_tag
// [RULE3] cdb and task attribute are latched from the COMMAND IU fields
// [RULE4] completion sends a RESPONSE IU carrying status and sense data
// [RULE5] task completion: response-valid clear, non-intermediate status
// [RULE6] linked completion: response-valid clear, intermediate status
// [RULE7] failure completion sends response-valid bit set
// [RULE8] initiator confirms completion on RESPONSE or NAK of its COMMAND
// [RULE9] initiator treats NAK or response-valid set as failure
// [RULE10] data-in IU offset derives from count of DATA IUs already sent
// [RULE11] data-in byte count equals the DATA IU payload size
// [RULE12] data-in delivered pulses only on ACK of a sent DATA IU; the mapper pulses on any ACK whose tag matches a slot in use
// [RULE13] write data requested by XFER_RDY carrying requested length
// [RULE14] data-out offset derives from count of DATA IUs received
// [RULE15] data-out received pulses for DATA IUs after our XFER_RDY
// [RULE16] initiator opens each command with a COMMAND IU
// [RULE17] one DATA IU counter per tag slot, cleared when RESPONSE sent
`timescale 1ns/1ps
`default_nettype none
`include "iu_map_defs.svh"
module iu_service_mapper (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // receive side from frame decode
    input wire logic conn_open,
    input wire logic [`ITID_W-1:0] conn_it,
    input wire logic rx_valid,
    input wire logic [2:0] rx_type,
    input wire logic [`LUN_W-1:0] rx_lun,
    input wire logic [`TAG_W-1:0] rx_tag,
    input wire logic [`CDB_W-1:0] rx_cdb,
    input wire logic [`ATTR_W-1:0] rx_attr,
    input wire logic [`LEN_W-1:0] rx_len,
    input wire logic ack_valid,
    input wire logic [`TAG_W-1:0] ack_tag,
    // device server requests
    input wire logic ds_slot_valid,
    input wire logic [`IDX_W-1:0] ds_slot,
    input wire logic [`LUN_W-1:0] ds_lun,
    input wire logic [`TAG_W-1:0] ds_tag,
    input wire logic req_data_in,
    input wire logic [`LEN_W-1:0] req_len,
    input wire logic req_xfer_rdy,
    input wire logic req_complete,
    input wire iu_map_pkg::cmpl_e req_kind,
    input wire logic [7:0] req_status,
    input wire logic [`SENSE_W-1:0] req_sense,
    // service indications to device server
    output logic cmd_received,
    output logic data_in_delivered,
    output logic data_out_received,
    output logic [`ITID_W-1:0] ev_it,
    output logic [`LUN_W-1:0] ev_lun,
    output logic [`TAG_W-1:0] ev_tag,
    output logic [`CDB_W-1:0] ev_cdb,
    output logic [`ATTR_W-1:0] ev_attr,
    output logic [`LEN_W-1:0] ev_len,
    output logic [`CNT_W-1:0] ev_offset,
    // transmit side to frame encode
    output logic tx_valid,
    output logic [2:0] tx_type,
    output logic [`LUN_W-1:0] tx_lun,
    output logic [`TAG_W-1:0] tx_tag,
    output logic [`LEN_W-1:0] tx_len,
    output logic [`CNT_W-1:0] tx_offset,
    output logic [7:0] tx_status,
    output logic [`SENSE_W-1:0] tx_sense,
    output logic response_info_valid_bit
);
    import iu_map_pkg::*;

    // ********************************************************
    // per-slot state
    // ********************************************************
    logic [`NTAGS-1:0] sl_used_r, sl_used_nxt;
    logic [`NTAGS-1:0] sl_xr_r, sl_xr_nxt;
    logic [`TAG_W-1:0] sl_tag_r [`NTAGS];
    logic [`TAG_W-1:0] sl_tag_nxt [`NTAGS];
    logic [`CNT_W-1:0] sl_cnt_r [`NTAGS];
    logic [`CNT_W-1:0] sl_cnt_nxt [`NTAGS];
    logic [`NTAGS-1:0] rx_hit, ack_hit;
    logic rx_any, ack_any;
    logic [`IDX_W-1:0] rx_idx, ack_idx;

    // tag lookup for received IUs and ACKs, two comparators per slot
    genvar g;
    generate
        for (g = 0; g < `NTAGS; g++) begin : g_hit
            assign rx_hit[g] = sl_used_r[g] && (sl_tag_r[g] == rx_tag);
            assign ack_hit[g] = sl_used_r[g] && (sl_tag_r[g] == ack_tag);
        end
    endgenerate

    // encode hits to slot indices
    always_comb begin
        rx_idx = '0;
        ack_idx = '0;
        for (int i = 0; i < `NTAGS; i++) begin
            if (rx_hit[i]) rx_idx = `IDX_W'(i);
            if (ack_hit[i]) ack_idx = `IDX_W'(i);
        end
        rx_any = |rx_hit;
        ack_any = |ack_hit;
    end

    // ********************************************************
    // outputs next values
    // ********************************************************
    logic cmd_nxt, din_nxt, dout_nxt, txv_nxt, rspv_nxt;
    logic [2:0] txt_nxt;
    logic [`ITID_W-1:0] it_nxt;
    logic [`LUN_W-1:0] elun_nxt, tlun_nxt;
    logic [`TAG_W-1:0] etag_nxt, ttag_nxt;
    logic [`CDB_W-1:0] cdb_nxt;
    logic [`ATTR_W-1:0] attr_nxt;
    logic [`LEN_W-1:0] elen_nxt, tlen_nxt;
    logic [`CNT_W-1:0] eoff_nxt, toff_nxt;
    logic [7:0] st_nxt;
    logic [`SENSE_W-1:0] sense_nxt;

    // service mapping and slot updates
    always_comb begin
        sl_used_nxt = sl_used_r;
        sl_xr_nxt = sl_xr_r;
        sl_tag_nxt = sl_tag_r;
        sl_cnt_nxt = sl_cnt_r;
        cmd_nxt = 1'b0;
        din_nxt = 1'b0;
        dout_nxt = 1'b0;
        it_nxt = ev_it;
        elun_nxt = ev_lun;
        etag_nxt = ev_tag;
        cdb_nxt = ev_cdb;
        attr_nxt = ev_attr;
        elen_nxt = ev_len;
        eoff_nxt = ev_offset;
        txv_nxt = 1'b0;
        txt_nxt = tx_type;
        tlun_nxt = tx_lun;
        ttag_nxt = tx_tag;
        tlen_nxt = tx_len;
        toff_nxt = tx_offset;
        st_nxt = tx_status;
        sense_nxt = tx_sense;
        rspv_nxt = response_info_valid_bit;
        // receive path: events only over an open connection
        if (rx_valid && conn_open) begin
            it_nxt = conn_it; // RULE2
            elun_nxt = rx_lun; // RULE2
            etag_nxt = rx_tag; // RULE2
            if (rx_type == `IU_COMMAND) begin
                cmd_nxt = 1'b1; // RULE1
                cdb_nxt = rx_cdb; // RULE3
                attr_nxt = rx_attr; // RULE3
            end else if (rx_type == `IU_DATA && rx_any && sl_xr_r[rx_idx]) begin
                dout_nxt = 1'b1; // RULE15
                elen_nxt = rx_len;
                eoff_nxt = sl_cnt_r[rx_idx]; // RULE14
                sl_cnt_nxt[rx_idx] = sl_cnt_r[rx_idx] + `CNT_ONE; // RULE14
            end
        end
        // any ack whose tag matches a slot in use
        if (ack_valid && ack_any) begin
            din_nxt = 1'b1; // RULE12
            it_nxt = conn_it;
            etag_nxt = ack_tag; // RULE2
        end
        // transmit path: one device server request per cycle
        if (ds_slot_valid) begin
            tlun_nxt = ds_lun; // RULE2
            ttag_nxt = ds_tag; // RULE2
            sl_used_nxt[ds_slot] = 1'b1;
            sl_tag_nxt[ds_slot] = ds_tag;
            if (req_complete) begin
                txv_nxt = 1'b1;
                txt_nxt = `IU_RESPONSE; // RULE4
                st_nxt = req_status; // RULE4
                sense_nxt = req_sense; // RULE4
                case (req_kind)
                    CMPL_TASK: rspv_nxt = `RSPV_CLEAR; // RULE5
                    CMPL_LINKED: rspv_nxt = `RSPV_CLEAR; // RULE6
                    CMPL_FAILURE: rspv_nxt = `RSPV_SET; // RULE7
                    default: rspv_nxt = `RSPV_SET;
                endcase
                // force status class to match the completion kind
                if (req_kind == CMPL_LINKED && req_status != `ST_INTER_CMET)
                    st_nxt = `ST_INTERMEDIATE; // RULE6
                if (req_kind == CMPL_TASK && (req_status == `ST_INTERMEDIATE ||
                        req_status == `ST_INTER_CMET))
                    st_nxt = `ST_GOOD; // RULE5
                sl_used_nxt[ds_slot] = 1'b0;
                sl_xr_nxt[ds_slot] = 1'b0;
                sl_cnt_nxt[ds_slot] = `CNT_ZERO; // RULE17
            end else if (req_data_in) begin
                txv_nxt = 1'b1;
                txt_nxt = `IU_DATA; // RULE10
                tlen_nxt = req_len; // RULE11
                toff_nxt = sl_cnt_r[ds_slot]; // RULE10
                sl_cnt_nxt[ds_slot] = sl_cnt_r[ds_slot] + `CNT_ONE; // RULE17
            end else if (req_xfer_rdy) begin
                txv_nxt = 1'b1;
                txt_nxt = `IU_XFER_RDY; // RULE13
                tlen_nxt = req_len; // RULE13
                sl_xr_nxt[ds_slot] = 1'b1; // RULE15
            end
        end
    end

    // ********************************************************
    // registers
    // ********************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            sl_used_r <= '0;
            sl_xr_r <= '0;
            for (int i = 0; i < `NTAGS; i++) begin
                sl_tag_r[i] <= '0;
                sl_cnt_r[i] <= `CNT_ZERO;
            end
            cmd_received <= 1'b0;
            data_in_delivered <= 1'b0;
            data_out_received <= 1'b0;
            ev_it <= '0;
            ev_lun <= '0;
            ev_tag <= '0;
            ev_cdb <= '0;
            ev_attr <= '0;
            ev_len <= '0;
            ev_offset <= `CNT_ZERO;
            tx_valid <= 1'b0;
            tx_type <= '0;
            tx_lun <= '0;
            tx_tag <= '0;
            tx_len <= '0;
            tx_offset <= `CNT_ZERO;
            tx_status <= '0;
            tx_sense <= '0;
            response_info_valid_bit <= `RSPV_CLEAR;
        end else begin
            sl_used_r <= sl_used_nxt;
            sl_xr_r <= sl_xr_nxt;
            sl_tag_r <= sl_tag_nxt;
            sl_cnt_r <= sl_cnt_nxt;
            cmd_received <= cmd_nxt;
            data_in_delivered <= din_nxt;
            data_out_received <= dout_nxt;
            ev_it <= it_nxt;
            ev_lun <= elun_nxt;
            ev_tag <= etag_nxt;
            ev_cdb <= cdb_nxt;
            ev_attr <= attr_nxt;
            ev_len <= elen_nxt;
            ev_offset <= eoff_nxt;
            tx_valid <= txv_nxt;
            tx_type <= txt_nxt;
            tx_lun <= tlun_nxt;
            tx_tag <= ttag_nxt;
            tx_len <= tlen_nxt;
            tx_offset <= toff_nxt;
            tx_status <= st_nxt;
            tx_sense <= sense_nxt;
            response_info_valid_bit <= rspv_nxt;
        end
    end
endmodule
`default_nettype wire

// ### iu_map_defs.svh
/*
 * Constants for the target-side IU to protocol-service mapper:
 * IU type codes, field widths, status codes, tag table size.
 * Assumes nothing; definitions only.
 */
`ifndef IU_MAP_DEFS_SVH
`define IU_MAP_DEFS_SVH

// ************************************************************
// IU type codes on the frame interface
// ************************************************************
`define IU_COMMAND 3'h1
`define IU_DATA 3'h2
`define IU_XFER_RDY 3'h3
`define IU_RESPONSE 3'h4

// ************************************************************
// field widths and table size
// ************************************************************
`define LUN_W 64
`define TAG_W 16
`define CDB_W 128
`define ATTR_W 3
`define ITID_W 8
`define LEN_W 32
`define SENSE_W 64
`define NTAGS 4
`define IDX_W 2
`define CNT_W 16

// ************************************************************
// status codes with linked-command meaning
// ************************************************************
`define ST_INTERMEDIATE 8'h10
`define ST_INTER_CMET 8'h14
`define ST_GOOD 8'h00

// ************************************************************
// response-valid bit values and DATA IU counter constants
// ************************************************************
`define RSPV_CLEAR 1'h0
`define RSPV_SET 1'h1
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001

`endif

// ### iu_map_pkg.sv
/*
 * Types shared by the mapper: completion kinds.
 * Assumes iu_map_defs.svh is on the include path.
 */
`default_nettype none
`include "iu_map_defs.svh"
package iu_map_pkg;
    // completion kinds from the device server
    typedef enum logic [1:0] {
        CMPL_TASK = 2'h0,
        CMPL_LINKED = 2'h1,
        CMPL_FAILURE = 2'h2
    } cmpl_e;
    typedef logic [`TAG_W-1:0] tag_t;
endpackage
`default_nettype wire

// ### iu_map_sva.sv
/* checker for the IU service mapper: command events, completions, acks.
   assumes it is bound to iu_service_mapper and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "iu_map_defs.svh"
module iu_map_sva (
    // receive side and events
    input wire logic clk, rst, conn_open, rx_valid, ack_valid, cmd_received, data_in_delivered,
    input wire logic data_out_received,
    input wire logic [2:0] rx_type, tx_type,
    input wire logic [`LUN_W-1:0] rx_lun, ev_lun,
    input wire logic [`TAG_W-1:0] rx_tag, ev_tag,
    input wire logic [`CDB_W-1:0] rx_cdb, ev_cdb,
    input wire logic [`ATTR_W-1:0] rx_attr, ev_attr,
    // requests and transmit side
    input wire logic ds_slot_valid, req_data_in, req_xfer_rdy, req_complete,
    input wire iu_map_pkg::cmpl_e req_kind,
    input wire logic [`LEN_W-1:0] req_len, tx_len,
    input wire logic [`SENSE_W-1:0] req_sense, tx_sense,
    input wire logic tx_valid, response_info_valid_bit,
    input wire logic [7:0] tx_status
);
    import iu_map_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // request qualifiers
    wire cmd_in = rx_valid && conn_open && rx_type == `IU_COMMAND && !ack_valid;
    wire cpl = ds_slot_valid && req_complete;
    wire mid = tx_status == `ST_INTERMEDIATE || tx_status == `ST_INTER_CMET;
    a_cmd_nexus: assert property (
        cmd_in |=> cmd_received && ev_tag == $past(rx_tag) && ev_lun == $past(rx_lun))
        else $error("command nexus not carried");
    a_cmd_fields: assert property (
        cmd_in |=> ev_cdb == $past(rx_cdb) && ev_attr == $past(rx_attr))
        else $error("cdb or attribute not carried");
    a_cmd_cause: assert property (
        cmd_received |-> $past(rx_valid && conn_open && rx_type == `IU_COMMAND))
        else $error("command event without command iu");
    a_rsp_fields: assert property (
        cpl |=> tx_valid && tx_type == `IU_RESPONSE && tx_sense == $past(req_sense))
        else $error("response iu fields wrong");
    a_fail_bit: assert property (
        cpl && req_kind == CMPL_FAILURE |=> response_info_valid_bit)
        else $error("failure sent without valid bit");
    a_linked_mid: assert property (
        cpl && req_kind == CMPL_LINKED |=> !response_info_valid_bit && mid)
        else $error("linked completion encoding wrong");
    a_task_final: assert property (
        cpl && req_kind == CMPL_TASK |=> !response_info_valid_bit && !mid)
        else $error("task completion encoding wrong");
    a_dout_cause: assert property (
        data_out_received |-> $past(rx_valid && conn_open && rx_type == `IU_DATA))
        else $error("data-out event without data iu");
    a_xfer_len: assert property (
        ds_slot_valid && req_xfer_rdy && !req_complete && !req_data_in
        |=> tx_type == `IU_XFER_RDY && tx_len == $past(req_len))
        else $error("xfer ready length wrong");
    a_ack_first: assert property (
        data_in_delivered |-> $past(ack_valid))
        else $error("delivery without ack");
endmodule
bind iu_service_mapper iu_map_sva i_sva (.*);
`default_nettype wire

// ### iu_init_model.sv
/* far-end initiator model: acknowledges every DATA IU the mapper sends.
   assumes the bench sets the ack pacing. */
`timescale 1ns/1ps
`default_nettype none
`include "iu_map_defs.svh"
module iu_init_model (
    // clock, reset, mapper transmit side, pacing
    input wire logic clk,
    input wire logic rst,
    input wire logic tx_valid,
    input wire logic [2:0] tx_type,
    input wire logic [`TAG_W-1:0] tx_tag,
    input wire logic response_info_valid_bit,
    input wire logic [3:0] ack_delay,
    // acknowledge to the mapper, completion confirmations seen
    output logic ack_valid,
    output logic [`TAG_W-1:0] ack_tag,
    output int confirm_cnt,
    output int failure_cnt
);
    // every RESPONSE IU confirms its command; valid bit set means failure
    always @(posedge clk) begin
        if (rst) begin
            confirm_cnt <= 0;
            failure_cnt <= 0;
        end else if (tx_valid && tx_type == `IU_RESPONSE) begin
            confirm_cnt <= confirm_cnt + 1;
            if (response_info_valid_bit) failure_cnt <= failure_cnt + 1;
        end
    end
    // one ack after the set delay, echoing the tag
    task automatic send_ack(input logic [`TAG_W-1:0] t);
        repeat (ack_delay) @(posedge clk);
        ack_valid <= 1'b1;
        ack_tag <= t;
        @(posedge clk);
        ack_valid <= 1'b0;
        ack_tag <= ~t; // no stale tag once released
    endtask
    initial begin
        ack_valid = 1'b0;
        ack_tag = 16'h0000;
    end
    // each data iu outside reset gets its own ack
    always @(posedge clk) begin
        if (!rst && tx_valid && tx_type == `IU_DATA) begin
            fork
                send_ack(tx_tag);
            join_none
        end
    end
endmodule
`default_nettype wire

// ### testbench.sv
/* self-checking bench for the IU service mapper with initiator model.
   assumes the mapper, its checker and the initiator model are compiled. */
`timescale 1ns/1ps
`default_nettype none
`include "iu_map_defs.svh"
module testbench;
    import iu_map_pkg::*;
    // stimulus and observed signals
    logic clk, rst, conn_open, rx_valid, ack_valid, ds_slot_valid, req_data_in, req_xfer_rdy;
    logic req_complete, cmd_received, data_in_delivered, data_out_received, tx_valid;
    logic response_info_valid_bit;
    logic [2:0] rx_type, rx_attr, tx_type, ev_attr;
    logic [1:0] ds_slot;
    logic [3:0] ack_delay;
    logic [7:0] conn_it, ev_it, req_status, tx_status;
    logic [`TAG_W-1:0] rx_tag, ack_tag, ds_tag, ev_tag, tx_tag, ev_offset, tx_offset;
    logic [`LEN_W-1:0] rx_len, req_len, ev_len, tx_len;
    logic [`LUN_W-1:0] rx_lun, ds_lun, ev_lun, tx_lun, req_sense, tx_sense;
    logic [`CDB_W-1:0] rx_cdb, ev_cdb;
    cmpl_e req_kind;
    int error_cnt, comparisons, din_cnt, confirm_cnt, failure_cnt;
    iu_service_mapper i_dut (.*);
    iu_init_model i_init (.*);
    // clock, delivery count, watchdog
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) if (data_in_delivered === 1'b1) din_cnt++;
    initial begin
        #300000;
        error_cnt++;
        report_and_stop;
    end
    task automatic report_and_stop;
        if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // one received iu, then the line is released
    task automatic rx(input logic [2:0] t, input logic [`TAG_W-1:0] tag, input logic c);
        @(posedge clk);
        #10;
        {rx_valid, rx_type, rx_tag, conn_open} = {1'b1, t, tag, c};
        @(posedge clk);
        #10;
        {rx_valid, rx_tag} = {1'b0, ~tag};
    endtask
    // one device server request: complete, data-in, xfer-ready bits
    task automatic req(input logic [2:0] b, input logic [1:0] s, input logic [`TAG_W-1:0] tag);
        @(posedge clk);
        #10;
        {ds_slot_valid, req_complete, req_data_in, req_xfer_rdy, ds_slot, ds_tag} = {1'b1, b, s, tag};
        @(posedge clk);
        #10;
        {ds_slot_valid, req_complete, req_data_in, req_xfer_rdy} = 4'h0;
    endtask
    task automatic t_cmd;
        rx(`IU_COMMAND, 16'h00A1, 1'b1);
        chk(cmd_received, 1'b1);
        chk({ev_it, ev_lun, ev_tag}, {conn_it, rx_lun, 16'h00A1});
        chk(ev_cdb, rx_cdb);
        chk(ev_attr, rx_attr);
        rx(`IU_COMMAND, 16'h00A2, 1'b0);
        chk(cmd_received, 1'b0);
    endtask
    task automatic t_din;
        req_len = 32'h0000_0400;
        ack_delay = 4'h6;
        req(3'h2, 2'h0, 16'h00A1);
        chk({tx_type, tx_tag, tx_len, tx_offset}, {`IU_DATA, 16'h00A1, req_len, `CNT_ZERO});
        chk({tx_valid, tx_lun}, {1'b1, ds_lun});
        req(3'h2, 2'h0, 16'h00A1);
        chk(tx_offset, `CNT_ONE);
        repeat (3) @(posedge clk);
        #10;
        chk(din_cnt, 0);
        for (int i = 0; i < 30 && din_cnt < 2; i++) @(posedge clk);
        #10;
        chk(din_cnt, 2);
    endtask
    task automatic t_dout;
        rx(`IU_DATA, 16'h00B2, 1'b1);
        chk(data_out_received, 1'b0);
        req_len = 32'h0000_0800;
        req(3'h1, 2'h1, 16'h00B2);
        chk({tx_type, tx_len}, {`IU_XFER_RDY, req_len});
        for (int i = 0; i < 2; i++) begin
            rx(`IU_DATA, 16'h00B2, 1'b1);
            chk({data_out_received, ev_offset, ev_len}, {1'b1, i[15:0], rx_len});
        end
    endtask
    task automatic t_cmpl;
        for (int k = 0; k < 3; k++) begin
            req_kind = cmpl_e'(k);
            req_status = k == 1 ? `ST_INTER_CMET : 8'h02;
            req_sense = {8{k[7:0]}};
            req(3'h4, 2'h0, 16'h00A1);
            chk({tx_type, response_info_valid_bit, tx_sense}, {`IU_RESPONSE, k == 2, req_sense});
            if (k < 2) chk(tx_status, req_status);
        end
        req_kind = CMPL_TASK;
        req_status = `ST_INTERMEDIATE;
        req(3'h4, 2'h0, 16'h00A1);
        chk(tx_status, `ST_GOOD);
        req_kind = CMPL_LINKED;
        req_status = 8'h02;
        req(3'h4, 2'h0, 16'h00A1);
        chk(tx_status, `ST_INTERMEDIATE);
        req(3'h2, 2'h0, 16'h00A1);
        chk(tx_offset, `CNT_ZERO);
        chk(confirm_cnt, 5);
        chk(failure_cnt, 1);
    endtask
    initial begin
        {rst, conn_open, rx_valid, ds_slot_valid, req_data_in, req_xfer_rdy, req_complete} = 7'h40;
        {conn_it, rx_type, rx_attr, rx_tag, rx_len} = {8'h3C, 3'h0, 3'h5, 16'h0000, 32'h0000_0200};
        rx_lun = 64'h0000_0000_0000_0007;
        rx_cdb = 128'hC3A5_0F0F_1111_2222_2800_1234_5678_9ABC;
        ds_lun = 64'h0000_0000_0000_0009;
        {ds_slot, ds_tag, req_len, req_status, req_sense, ack_delay} = '0;
        req_kind = CMPL_TASK;
        {error_cnt, comparisons, din_cnt} = '0;
        repeat (6) @(posedge clk);
        #10;
        rst = 1'b0;
        t_cmd;
        t_din;
        t_dout;
        t_cmpl;
        report_and_stop;
    end
endmodule
`default_nettype wire
